// *** flpe_regs.svh ***
`ifndef FLPE_REGS_SVH
`define FLPE_REGS_SVH
`define FLPE_AV_AW 20
`define FLPE_FIRST_UNLOCK_KEY 32'h45670123
`define FLPE_SECOND_UNLOCK_KEY 32'hcdef89ab
`define FLPE_RDP_KEY 8'ha5
`define FLPE_ERASED 16'hffff
`define FLPE_OPT_HW 8
`define FLPE_WRP_W 32
`define FLPE_PROG_CYC 8
`define FLPE_OFS_KEY 8'h04
`define FLPE_OFS_OPTKEY 8'h08
`define FLPE_OFS_SR 8'h0c
`define FLPE_OFS_CR 8'h10
`define FLPE_OFS_AR 8'h14
`define FLPE_OFS_OBR 8'h1c
`define FLPE_OFS_WRPR 8'h20
`define FLPE_SR_BSY 0
`define FLPE_SR_PROGRAM_ERROR_FLAG 2
`define FLPE_SR_WPERR 4
`define FLPE_SR_DONE 5
`define FLPE_CR_PG 0
`define FLPE_CR_PER 1
`define FLPE_CR_MER 2
`define FLPE_CR_OPTION_PROGRAM_ENABLE 4
`define FLPE_CR_OPTION_ERASE_SELECT 5
`define FLPE_CR_START_OPERATION 6
`define FLPE_CR_LOCK 7
`define FLPE_CR_OPTION_WRITE_ENABLE 9
`define FLPE_RESP_OK 2'h0
`define FLPE_RESP_ERR 2'h2
`endif

// *** flpe_pkg.sv ***
`include "flpe_regs.svh"
package flpe_pkg;
    typedef struct packed {
        logic [`FLPE_AV_AW-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } flpe_av_req_t;
    typedef enum logic [1:0] {
        FLPE_IDLE = 2'b00,
        FLPE_PROG = 2'b01,
        FLPE_ERASE = 2'b10
    } flpe_state_t;
endpackage : flpe_pkg

// *** flpe_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "flpe_regs.svh"
module flpe_ctrl #(
    parameter int PAGES = 128,
    parameter int PAGE_HW = 512,
    parameter int PROG_CYC = `FLPE_PROG_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire flpe_pkg::flpe_av_req_t i_av,
    input wire logic i_debug,
    output logic o_waitrequest,
    output logic [31:0] o_readdata,
    output logic [1:0] o_response,
    output logic o_readout_protected
);
    import flpe_pkg::*;
    localparam int MAIN_HW = PAGES * PAGE_HW;
    localparam int HW_W = $clog2(MAIN_HW);
    localparam int PG_W = $clog2(PAGES);
    localparam int PO_W = $clog2(PAGE_HW);
    localparam int CNT_W = $clog2(PROG_CYC + 1);

    logic [15:0] main_mem [MAIN_HW];
    logic [15:0] opt_mem [`FLPE_OPT_HW];
    flpe_state_t state;
    logic ack, busy, locked, lockout, key_stage, opt_stage, option_write_enable;
    logic pg, page_erase_select, mass_erase_select, option_program_enable, option_erase_select, start_operation;
    logic done_flag, program_error_flag_flag, wperr_flag;
    logic [31:0] ar;
    logic [HW_W-1:0] ptr, last, tgt_idx;
    logic [15:0] tgt_data;
    logic [CNT_W-1:0] cnt;
    logic e_opt, t_opt, pend;

    initial begin
        for (int i = 0; i < MAIN_HW; i++) main_mem[i] = `FLPE_ERASED;
        for (int i = 0; i < `FLPE_OPT_HW; i++) opt_mem[i] = `FLPE_ERASED;
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic req, rd, wr, fire, stall, half_ok;
    logic sel_main, sel_opt, sel_reg, sel_key, sel_okey, sel_sr, sel_cr, sel_ar;
    logic sel_obr, sel_wrpr, mapped, reg_wr;
    logic [7:0] ofs;
    logic [31:0] wd;
    logic [15:0] wd_hw;
    logic [HW_W-1:0] hw_idx;
    logic [2:0] opt_idx;
    logic rdprot;
    logic [`FLPE_WRP_W-1:0] write_guard_bytes;

    assign rd = i_av.read;
    assign wr = i_av.write;
    assign req = rd || wr;
    assign wd = i_av.writedata;
    assign ofs = i_av.address[7:0];
    assign sel_main = i_av.address[`FLPE_AV_AW-1:17] == 3'h0;
    assign sel_opt = i_av.address[`FLPE_AV_AW-1:18] == 2'h2;
    assign sel_reg = i_av.address[`FLPE_AV_AW-1:18] == 2'h3;
    assign sel_key = sel_reg && ofs == `FLPE_OFS_KEY;
    assign sel_okey = sel_reg && ofs == `FLPE_OFS_OPTKEY;
    assign sel_sr = sel_reg && ofs == `FLPE_OFS_SR;
    assign sel_cr = sel_reg && ofs == `FLPE_OFS_CR;
    assign sel_ar = sel_reg && ofs == `FLPE_OFS_AR;
    assign sel_obr = sel_reg && ofs == `FLPE_OFS_OBR;
    assign sel_wrpr = sel_reg && ofs == `FLPE_OFS_WRPR;
    assign mapped = sel_main || sel_opt || sel_key || sel_okey || sel_sr || sel_cr
        || sel_ar || sel_obr || sel_wrpr;
    assign half_ok = i_av.byteenable == 4'h3 || i_av.byteenable == 4'hc;
    assign wd_hw = i_av.byteenable[2] ? wd[31:16] : wd[15:0];
    assign hw_idx = i_av.address[HW_W:1];
    assign opt_idx = i_av.address[3:1];
    // Flash side stalls while an operation runs
    assign stall = busy && (sel_main || sel_opt);
    assign o_waitrequest = req && !ack;
    assign fire = ack && wr;
    // Register writes ignored while busy
    assign reg_wr = fire && !busy;
    // Protected unless key byte and its complement stored
    assign rdprot = !(opt_mem[0][7:0] == `FLPE_RDP_KEY
        && opt_mem[0][15:8] == ~`FLPE_RDP_KEY);
    assign write_guard_bytes = {opt_mem[7][7:0], opt_mem[6][7:0], opt_mem[5][7:0], opt_mem[4][7:0]};
    assign o_readout_protected = rdprot;

    function automatic logic page_prot(input logic [PG_W-1:0] page);
        logic [PG_W-3:0] grp;
        grp = page[PG_W-1:2];
        // Four pages per guard bit, first group guarded under readout protection
        page_prot = !write_guard_bytes[grp] || (rdprot && grp == '0);
    endfunction : page_prot

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    logic key_err, err, mstr;
    logic [31:0] rd_val;

    assign key_err = sel_key && wr && locked
        && (lockout || (key_stage ? wd != `FLPE_SECOND_UNLOCK_KEY : wd != `FLPE_FIRST_UNLOCK_KEY));
    assign mstr = PAGE_HW == 0;
    assign err = !mapped || key_err
        || ((sel_main || sel_opt) && wr && !half_ok)
        || (sel_main && rd && rdprot && i_debug);

    always_comb begin
        rd_val = 32'h0;
        if (sel_main) begin
            rd_val = {main_mem[{hw_idx[HW_W-1:1], 1'b1}], main_mem[{hw_idx[HW_W-1:1], 1'b0}]};
        end else if (sel_opt) begin
            rd_val = {opt_mem[{opt_idx[2:1], 1'b1}], opt_mem[{opt_idx[2:1], 1'b0}]};
        end else if (sel_sr) begin
            rd_val[`FLPE_SR_BSY] = busy;
            rd_val[`FLPE_SR_PROGRAM_ERROR_FLAG] = program_error_flag_flag;
            rd_val[`FLPE_SR_WPERR] = wperr_flag;
            rd_val[`FLPE_SR_DONE] = done_flag;
        end else if (sel_cr) begin
            rd_val[`FLPE_CR_PG] = pg;
            rd_val[`FLPE_CR_PER] = page_erase_select;
            rd_val[`FLPE_CR_MER] = mass_erase_select;
            rd_val[`FLPE_CR_OPTION_PROGRAM_ENABLE] = option_program_enable;
            rd_val[`FLPE_CR_OPTION_ERASE_SELECT] = option_erase_select;
            rd_val[`FLPE_CR_START_OPERATION] = start_operation;
            rd_val[`FLPE_CR_LOCK] = locked;
            rd_val[`FLPE_CR_OPTION_WRITE_ENABLE] = option_write_enable;
        end else if (sel_ar) begin
            rd_val = ar;
        end else if (sel_obr) begin
            rd_val = {22'h0, opt_mem[1][7:0], rdprot, 1'b0};
        end else if (sel_wrpr) begin
            rd_val = write_guard_bytes;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack <= 1'b0;
            o_readdata <= 32'h0;
            o_response <= `FLPE_RESP_OK;
        end else begin
            ack <= req && !ack && !stall;
            if (req && !ack && !stall) begin
                o_readdata <= (rd && !err && !mstr) ? rd_val : 32'h0;
                o_response <= err ? `FLPE_RESP_ERR : `FLPE_RESP_OK;
            end
        end
    end

    // ----------------------------------------------------------------
    // Lock and keys
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            locked <= 1'b1;
            lockout <= 1'b0;
            key_stage <= 1'b0;
            opt_stage <= 1'b0;
            option_write_enable <= 1'b0;
        end else if (reg_wr) begin
            if (sel_key && locked && !lockout) begin
                if (!key_stage && wd == `FLPE_FIRST_UNLOCK_KEY) begin
                    key_stage <= 1'b1;
                end else if (key_stage && wd == `FLPE_SECOND_UNLOCK_KEY) begin
                    key_stage <= 1'b0;
                    locked <= 1'b0;
                end else begin
                    key_stage <= 1'b0;
                    lockout <= 1'b1;
                end
            end
            if (sel_okey && !locked) begin
                if (!opt_stage && wd == `FLPE_FIRST_UNLOCK_KEY) begin
                    opt_stage <= 1'b1;
                end else if (opt_stage && wd == `FLPE_SECOND_UNLOCK_KEY) begin
                    opt_stage <= 1'b0;
                    option_write_enable <= 1'b1;
                end else begin
                    opt_stage <= 1'b0;
                end
            end
            if (sel_cr && !locked) begin
                if (wd[`FLPE_CR_LOCK]) begin
                    locked <= 1'b1;
                    option_write_enable <= 1'b0;
                    opt_stage <= 1'b0;
                end else if (!wd[`FLPE_CR_OPTION_WRITE_ENABLE]) begin
                    option_write_enable <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Operation launch
    // ----------------------------------------------------------------
    logic cr_wr, start_operation_fire, go_prog, go_erase, go_mass_pre, abort;
    logic ev_program_error_flag, ev_wperr, ev_done;
    logic [HW_W-1:0] e_first, e_last;
    logic [PG_W-1:0] ar_page;

    assign cr_wr = reg_wr && sel_cr && !locked;
    assign start_operation_fire = cr_wr && wd[`FLPE_CR_START_OPERATION];
    assign ar_page = ar[HW_W:PO_W+1];

    always_comb begin
        go_prog = 1'b0;
        go_erase = 1'b0;
        go_mass_pre = 1'b0;
        abort = 1'b0;
        ev_program_error_flag = 1'b0;
        ev_wperr = 1'b0;
        e_first = '0;
        e_last = '0;
        if (fire && sel_main && half_ok && pg) begin
            if (page_prot(hw_idx[HW_W-1:PO_W])) begin
                ev_wperr = 1'b1;
            end else if (main_mem[hw_idx] != `FLPE_ERASED && wd_hw != 16'h0) begin
                ev_program_error_flag = 1'b1;
            end else begin
                go_prog = 1'b1;
            end
        end else if (fire && sel_opt && half_ok && option_program_enable && option_write_enable) begin
            if (opt_mem[opt_idx] != `FLPE_ERASED) begin
                ev_wperr = 1'b1;
            end else if (opt_idx == 3'h0 && rdprot && wd_hw[7:0] == `FLPE_RDP_KEY) begin
                go_mass_pre = 1'b1;
                e_last = HW_W'(MAIN_HW - 1);
            end else begin
                go_prog = 1'b1;
            end
        end else if (start_operation_fire) begin
            if (wd[`FLPE_CR_OPTION_ERASE_SELECT] && option_write_enable) begin
                go_erase = 1'b1;
                e_last = HW_W'(`FLPE_OPT_HW - 1);
            end else if (wd[`FLPE_CR_MER] && !wd[`FLPE_CR_OPTION_ERASE_SELECT]) begin
                if (write_guard_bytes != '1 || rdprot) begin
                    ev_wperr = 1'b1;
                    abort = 1'b1;
                end else begin
                    go_erase = 1'b1;
                    e_last = HW_W'(MAIN_HW - 1);
                end
            end else if (wd[`FLPE_CR_PER] && !wd[`FLPE_CR_OPTION_ERASE_SELECT]) begin
                if (page_prot(ar_page)) begin
                    ev_wperr = 1'b1;
                    abort = 1'b1;
                end else begin
                    go_erase = 1'b1;
                    e_first = {ar_page, PO_W'(0)};
                    e_last = {ar_page, {PO_W{1'b1}}};
                end
            end else begin
                abort = 1'b1;
            end
        end
    end

    assign ev_done = (state == FLPE_ERASE && ptr == last && !pend)
        || (state == FLPE_PROG && cnt == '0);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {pg, page_erase_select, mass_erase_select, option_program_enable, option_erase_select, start_operation} <= 6'h0;
            ar <= 32'h0;
        end else begin
            if (cr_wr) begin
                pg <= wd[`FLPE_CR_PG];
                page_erase_select <= wd[`FLPE_CR_PER];
                mass_erase_select <= wd[`FLPE_CR_MER];
                option_program_enable <= wd[`FLPE_CR_OPTION_PROGRAM_ENABLE];
                option_erase_select <= wd[`FLPE_CR_OPTION_ERASE_SELECT];
                start_operation <= wd[`FLPE_CR_START_OPERATION] && !abort;
            end else if (ev_done && state == FLPE_ERASE) begin
                start_operation <= 1'b0;
            end
            if (reg_wr && sel_ar) begin
                ar <= wd;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= FLPE_IDLE;
            busy <= 1'b0;
            ptr <= '0;
            last <= '0;
            cnt <= '0;
            tgt_idx <= '0;
            tgt_data <= 16'h0;
            {e_opt, t_opt, pend} <= 3'h0;
        end else begin
            case (state)
                FLPE_IDLE: begin
                    if (go_prog || go_mass_pre) begin
                        t_opt <= sel_opt;
                        tgt_idx <= sel_opt ? HW_W'(opt_idx) : hw_idx;
                        // Option high byte is the complement of the low byte
                        tgt_data <= sel_opt ? {~wd_hw[7:0], wd_hw[7:0]} : wd_hw;
                        cnt <= CNT_W'(PROG_CYC - 1);
                    end
                    if (go_prog) begin
                        state <= FLPE_PROG;
                        busy <= 1'b1;
                    end else if (go_erase || go_mass_pre) begin
                        state <= FLPE_ERASE;
                        busy <= 1'b1;
                        ptr <= e_first;
                        last <= e_last;
                        e_opt <= go_erase && wd[`FLPE_CR_OPTION_ERASE_SELECT];
                        pend <= go_mass_pre;
                    end
                end
                FLPE_ERASE: begin
                    ptr <= ptr + 1'b1;
                    if (ptr == last) begin
                        state <= pend ? FLPE_PROG : FLPE_IDLE;
                        busy <= pend;
                        pend <= 1'b0;
                    end
                end
                FLPE_PROG: begin
                    cnt <= cnt - 1'b1;
                    if (cnt == '0) begin
                        state <= FLPE_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    state <= FLPE_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Flash arrays
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (state == FLPE_ERASE && !e_opt) begin
            main_mem[ptr] <= `FLPE_ERASED;
        end else if (state == FLPE_PROG && cnt == '0 && !t_opt) begin
            main_mem[tgt_idx] <= tgt_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (state == FLPE_ERASE && e_opt) begin
            opt_mem[ptr[2:0]] <= `FLPE_ERASED;
        end else if (state == FLPE_PROG && cnt == '0 && t_opt) begin
            opt_mem[tgt_idx[2:0]] <= tgt_data;
        end
    end

    // ----------------------------------------------------------------
    // Status flags, set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {done_flag, program_error_flag_flag, wperr_flag} <= 3'h0;
        end else begin
            if (ev_done) begin
                done_flag <= 1'b1;
            end else if (reg_wr && sel_sr && wd[`FLPE_SR_DONE]) begin
                done_flag <= 1'b0;
            end
            if (ev_program_error_flag) begin
                program_error_flag_flag <= 1'b1;
            end else if (reg_wr && sel_sr && wd[`FLPE_SR_PROGRAM_ERROR_FLAG]) begin
                program_error_flag_flag <= 1'b0;
            end
            if (ev_wperr) begin
                wperr_flag <= 1'b1;
            end else if (reg_wr && sel_sr && wd[`FLPE_SR_WPERR]) begin
                wperr_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_locked_cr_ignored: assert property (
        fire && sel_cr && locked |=> $stable({pg, page_erase_select, mass_erase_select, option_program_enable, option_erase_select}))
        else $error("control written while locked");
    a_key_unlock: assert property (
        reg_wr && sel_key && locked && !lockout && key_stage && wd == `FLPE_SECOND_UNLOCK_KEY
        |=> !locked) else $error("correct key pair did not unlock");
    a_lockout_held: assert property (
        lockout |=> lockout && locked) else $error("lockout released before reset");
    a_key_error: assert property (
        req && !ack && !stall && key_err |=> o_response == `FLPE_RESP_ERR && !o_waitrequest)
        else $error("wrong key without bus error");
    a_size_error: assert property (
        req && !ack && !stall && wr && sel_main && !half_ok |=> o_response == `FLPE_RESP_ERR)
        else $error("bad write size without bus error");
    a_busy_stall: assert property (
        busy && req && (sel_main || sel_opt) |-> o_waitrequest)
        else $error("flash access not stalled while busy");
    a_done_flag: assert property (
        state == FLPE_PROG && cnt == '0 |=> done_flag && !busy)
        else $error("done flag missing after program");
    a_busy_regs: assert property (
        busy && fire && sel_ar |=> $stable(ar))
        else $error("register written while busy");
    a_opt_complement: assert property (
        state == FLPE_PROG && t_opt |-> tgt_data[15:8] == ~tgt_data[7:0])
        else $error("option high byte not complement");
    // Cycles spent in the program state, for the busy length check
    logic [CNT_W:0] prog_len;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prog_len <= '0;
        end else if (state == FLPE_PROG) begin
            prog_len <= prog_len + 1'b1;
        end else begin
            prog_len <= '0;
        end
    end

    a_prog_length: assert property (
        state == FLPE_PROG && prog_len == (CNT_W + 1)'(PROG_CYC - 1) |=> !busy)
        else $error("program busy length wrong");
    a_prog_busy_held: assert property (
        state == FLPE_PROG && prog_len < (CNT_W + 1)'(PROG_CYC - 1) |=> busy)
        else $error("program busy dropped early");

    c_unlock: cover property (locked ##[1:50] !locked);
    c_program: cover property (state == FLPE_PROG ##[1:20] done_flag);
    c_lockout: cover property ($rose(lockout));
    c_opt_erase: cover property (state == FLPE_ERASE && e_opt);
endmodule : flpe_ctrl
`default_nettype wire

// *** flpe_cpu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Processor side bus master
// ----------------------------------------
module flpe_cpu_model (
    input wire logic i_ref_clk,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    input wire logic [1:0] i_response,
    output var flpe_pkg::flpe_av_req_t o_av
);
    import flpe_pkg::*;
    initial o_av = '0;
    // One access, held until waitrequest is seen low
    task automatic xfer(input logic rw, input logic [19:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
        @(posedge i_ref_clk);
        o_av <= '{address: a, read: ~rw, write: rw, writedata: d, byteenable: be};
        do @(posedge i_ref_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        r = i_response;
        o_av.read <= 1'b0;
        o_av.write <= 1'b0;
        o_av.writedata <= ~d;
    endtask : xfer
endmodule : flpe_cpu_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "flpe_regs.svh"
module tb;
    import flpe_pkg::*;
    localparam logic [19:0] A = 20'h00080;
    localparam logic [19:0] UKEY = {12'hc00, `FLPE_OFS_KEY};
    localparam logic [19:0] OKEY = {12'hc00, `FLPE_OFS_OPTKEY};
    localparam logic [19:0] STA = {12'hc00, `FLPE_OFS_SR};
    localparam logic [19:0] CTL = {12'hc00, `FLPE_OFS_CR};
    localparam logic [19:0] ADR = {12'hc00, `FLPE_OFS_AR};
    localparam logic [1:0] ER = `FLPE_RESP_ERR;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic dbg = 1'b0;
    flpe_av_req_t av;
    logic wreq, readout_protection_byte;
    logic [31:0] rdata, q;
    logic [1:0] resp, r;
    logic [15:0] hw;
    logic [15:0] mdl [int];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'hae05;
    flpe_ctrl #(.PAGES(8), .PAGE_HW(16), .PROG_CYC(8)) flpe_ctrl_inst (
        .i_ref_clk(clk), .i_resetn(rstn), .i_av(av), .i_debug(dbg),
        .o_waitrequest(wreq), .o_readdata(rdata), .o_response(resp),
        .o_readout_protected(readout_protection_byte));
    flpe_cpu_model flpe_cpu_model_inst (.i_ref_clk(clk), .i_waitrequest(wreq),
        .i_readdata(rdata), .i_response(resp), .o_av(av));
    initial forever #20 clk = ~clk;
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    function automatic logic [31:0] word(input int i);
        word[15:0] = mdl.exists(i) ? mdl[i] : `FLPE_ERASED;
        word[31:16] = mdl.exists(i + 1) ? mdl[i + 1] : `FLPE_ERASED;
    endfunction : word
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic w(input logic [19:0] a, input logic [31:0] d,
                     input logic [3:0] be = 4'hf, input logic [1:0] er = 2'h0);
        flpe_cpu_model_inst.xfer(1'b1, a, d, be, q, r);
        chk(r, er);
    endtask : w
    task automatic rd(input logic [19:0] a, input logic [31:0] e);
        flpe_cpu_model_inst.xfer(1'b0, a, 32'h0, 4'hf, q, r);
        chk(q, e);
    endtask : rd
    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        hw = 16'h8000 | 16'($random(seed)) & 16'h7ffe;
        @(posedge clk);
        chk(readout_protection_byte, 1);
        w(CTL, 32'h1);
        rd(CTL, 32'h80);
        w(UKEY, `FLPE_FIRST_UNLOCK_KEY);
        w(UKEY, `FLPE_SECOND_UNLOCK_KEY);
        rd(CTL, 32'h0);
        w(CTL, 32'h1);
        w(A, {16'h0, hw}, 4'h3);
        mdl[A / 2] = hw;
        rd(STA, 32'h1);
        rd(A, word(A / 2));
        rd(STA, 32'h20);
        w(STA, 32'h20);
        rd(STA, 32'h0);
        w(A, {16'h0, ~hw}, 4'h3);
        rd(STA, 32'h4);
        w(A, 32'h0, 4'h3);
        mdl[A / 2] = 16'h0;
        rd(A, word(A / 2));
        rd(STA, 32'h24);
        w(STA, 32'h34);
        w(A, 32'h1, 4'h1, ER);
        w(20'h0, {16'h0, hw}, 4'h3);
        rd(STA, 32'h10);
        rd(20'h0, 32'hffffffff);
        dbg <= 1'b1;
        w(A, 32'h0, 4'hf, ER);
        flpe_cpu_model_inst.xfer(1'b0, A, 32'h0, 4'hf, q, r);
        chk(r, ER);
        dbg <= 1'b0;
        w(CTL, 32'h0);
        w(ADR, {12'h0, A});
        w(CTL, 32'h42);
        for (int i = 64; i < 80; i++) mdl.delete(i);
        rd(A, word(A / 2));
        rd(CTL, 32'h2);
        w(OKEY, `FLPE_FIRST_UNLOCK_KEY);
        w(OKEY, `FLPE_SECOND_UNLOCK_KEY);
        rd(CTL, 32'h202);
        w(CTL, 32'h210);
        w(20'h80002, {24'h0000ff, hw[7:0]}, 4'h3);
        rd(20'h80000, {~hw[7:0], hw[7:0], 16'hffff});
        w(STA, 32'h34);
        w(20'h80002, 32'h1, 4'h3);
        rd(STA, 32'h10);
        w(CTL, 32'h80);
        rd(CTL, 32'h80);
        w(UKEY, `FLPE_SECOND_UNLOCK_KEY, 4'hf, ER);
        w(UKEY, `FLPE_FIRST_UNLOCK_KEY, 4'hf, ER);
        w(UKEY, `FLPE_SECOND_UNLOCK_KEY, 4'hf, ER);
        rd(CTL, 32'h80);
        finish_test();
    end
endmodule : tb
`default_nettype wire
